// File: rtl/nbx_cfg.svh
// Constants for the nibble bus I/O expander
`ifndef NBX_CFG_SVH
`define NBX_CFG_SVH
`define NBX_NIB_W      4
`define NBX_PORTS      4
`define NBX_OP_MSB     3
`define NBX_OP_LSB     2
`define NBX_ADDR_MSB   1
`define NBX_ADDR_LSB   0
`define NBX_OP_READ    2'h0
`define NBX_OP_DIRECT  2'h1
`define NBX_OP_OR      2'h2
`define NBX_OP_AND     2'h3
`define NBX_LATCH_RST  4'h0
`endif

// File: rtl/nbx_expander.sv
// Nibble bus I/O expander: four 4-bit ports behind a strobed nibble bus
// Functional notes
// - A transaction is two nibbles: opcode with port address, then data.
// - Falling strobe edge captures opcode and port address.
// - Low two bits of first nibble pick port a, b, c or d.
// - High two bits: 00 read, 01 direct, 10 OR, 11 AND.
// - Direct write replaces the port latch.
// - OR write ORs data into the old latch value.
// - AND write ANDs data into the old latch value.
// - Rising strobe edge takes write data and applies it.
// - Written port holds its value until written again; it drives until a read releases it.
// - A written port drives low impedance, not floating.
// - Decoded read releases the selected port's pins.
// - Read returns port pins on the host bus while strobe low.
// - Rising strobe ends a read; port stays released, host bus input.
// - Chip select high freezes ports, latches and phase; host bus goes input.
// - Power-up: all ports released, host bus input.
// - First falling strobe leaves power-on state as a normal capture.
`timescale 1ns/1ps
`include "nbx_cfg.svh"

module nbx_expander
   import nbx_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             transfer_strobe,
   input  wire logic             chip_select_n,
   input  wire logic [3:0]       host_nibble_bus_in,
   output logic      [3:0]       host_nibble_bus_out,
   output logic                  host_nibble_bus_oe_n,
   input  wire nbx_ports_t       io_port_in,
   output nbx_ports_t            io_port_out,
   output logic      [3:0]       io_port_oe_n
);

   nbx_state_t st_reg;
   nbx_state_t st_next;

   logic       fall;
   logic       rise;
   logic [3:0] sel_pins;
   logic [3:0] old_val;

   function automatic logic [3:0] nbx_pick(input logic [15:0] v, input logic [1:0] a);
      nbx_pick = v[(4'(3 - a)) * 4 +: 4];
   endfunction

   // Edge detect; strobe treated as synchronous
   // Limitation: each strobe level must last a full clock to be seen
   // Trade-off: one clock of edge latency buys a single action per edge
   // one action per edge
   assign fall = st_reg.strobe_q & ~transfer_strobe;
   assign rise = ~st_reg.strobe_q & transfer_strobe;

   assign sel_pins = nbx_pick(io_port_in, st_reg.addr);
   assign old_val  = nbx_pick(st_reg.latch, st_reg.addr);

   always_comb begin
      st_next = st_reg;
      // Strobe history tracks even when deselected so a stale edge never fires
      st_next.strobe_q = transfer_strobe;
      st_next.rd_ready = 1'b0;
      if (!chip_select_n) begin
         if (fall) begin
            // capture opcode and address; also leaves power-on
            // low bits port, high bits operation
            st_next.op   = host_nibble_bus_in[`NBX_OP_MSB:`NBX_OP_LSB];
            st_next.addr = host_nibble_bus_in[`NBX_ADDR_MSB:`NBX_ADDR_LSB];
            if (host_nibble_bus_in[`NBX_OP_MSB:`NBX_OP_LSB] == `NBX_OP_READ) begin
               st_next.phase = NBX_READ;
               st_next.driving[3 - host_nibble_bus_in[1:0]] = 1'b0;
            end else begin
               st_next.phase = NBX_WRITE;
            end
         end else begin
            unique case (st_reg.phase)
               NBX_POWERON, NBX_IDLE: begin
               end
               NBX_READ: begin
                  // return pin levels while strobe low
                  st_next.rd_data  = sel_pins;
                  st_next.rd_ready = 1'b1;
                  // rise ends the read, port stays released
                  if (rise) begin
                     st_next.phase = NBX_IDLE;
                  end
               end
               NBX_WRITE: begin
                  if (rise) begin
                     st_next.phase = NBX_IDLE;
                     st_next.driving[3 - st_reg.addr] = 1'b1;
                     unique case (st_reg.op)
                        `NBX_OP_DIRECT:
                           st_next.latch[(4'(3 - st_reg.addr)) * 4 +: 4] = host_nibble_bus_in;
                        `NBX_OP_OR:
                           st_next.latch[(4'(3 - st_reg.addr)) * 4 +: 4] =
                              old_val | host_nibble_bus_in;
                        default:
                           st_next.latch[(4'(3 - st_reg.addr)) * 4 +: 4] =
                              old_val & host_nibble_bus_in;
                     endcase
                  end
               end
            endcase
         end
      end
   end

   // power-on: ports released, host bus input
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '{phase:    NBX_POWERON,
                     strobe_q: 1'b0,
                     op:       2'h0,
                     addr:     2'h0,
                     latch:    {4{`NBX_LATCH_RST}},
                     driving:  4'h0,
                     rd_data:  4'h0,
                     rd_ready: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign io_port_out  = st_reg.latch;
   assign io_port_oe_n = ~st_reg.driving;

   // Bus driven only after one cycle of sampled pins, removed at once on rise
   assign host_nibble_bus_out  = st_reg.rd_data;
   assign host_nibble_bus_oe_n = ~(st_reg.phase == NBX_READ && st_reg.rd_ready
                                   && !transfer_strobe && !chip_select_n);

   // Assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   frozen_when_off_a: assert property (
      chip_select_n |=> (st_reg.latch == $past(st_reg.latch)
                         && st_reg.phase == $past(st_reg.phase)))
      else $error("state changed while deselected");

   capture_on_fall_a: assert property (
      (!chip_select_n && fall) |=> (st_reg.op == $past(host_nibble_bus_in[3:2])
                                    && st_reg.addr == $past(host_nibble_bus_in[1:0])))
      else $error("opcode not captured on falling strobe");

   direct_write_a: assert property (
      (!chip_select_n && rise && st_reg.phase == NBX_WRITE && st_reg.op == `NBX_OP_DIRECT)
      |=> nbx_pick(st_reg.latch, st_reg.addr) == $past(host_nibble_bus_in))
      else $error("direct write wrong");

   or_write_a: assert property (
      (!chip_select_n && rise && st_reg.phase == NBX_WRITE && st_reg.op == `NBX_OP_OR)
      |=> nbx_pick(st_reg.latch, st_reg.addr) == ($past(old_val) | $past(host_nibble_bus_in)))
      else $error("OR write wrong");

   and_write_a: assert property (
      (!chip_select_n && rise && st_reg.phase == NBX_WRITE && st_reg.op == `NBX_OP_AND)
      |=> nbx_pick(st_reg.latch, st_reg.addr) == ($past(old_val) & $past(host_nibble_bus_in)))
      else $error("AND write wrong");

   write_drives_a: assert property (
      (!chip_select_n && rise && st_reg.phase == NBX_WRITE)
      |=> io_port_oe_n[3 - st_reg.addr] == 1'b0)
      else $error("written port not driven");

   read_release_a: assert property (
      (!chip_select_n && fall && host_nibble_bus_in[3:2] == `NBX_OP_READ)
      |=> io_port_oe_n[3 - st_reg.addr] == 1'b1)
      else $error("read port still driven");

   read_return_a: assert property (
      (st_reg.phase == NBX_READ && !chip_select_n && !transfer_strobe) ##1
      (st_reg.phase == NBX_READ && !chip_select_n && !transfer_strobe)
      |-> (!host_nibble_bus_oe_n && host_nibble_bus_out == $past(sel_pins)))
      else $error("read data not on bus");

   read_end_a: assert property (
      (st_reg.phase == NBX_READ && !chip_select_n && rise)
      |=> (host_nibble_bus_oe_n && st_reg.phase == NBX_IDLE))
      else $error("read not ended by rise");

   poweron_quiet_a: assert property (
      st_reg.phase == NBX_POWERON |-> (io_port_oe_n == 4'hf && host_nibble_bus_oe_n))
      else $error("outputs driven at power-on");

   cov_write_c: cover property (st_reg.phase == NBX_WRITE ##[1:50] st_reg.phase == NBX_IDLE);
   cov_read_c: cover property (st_reg.phase == NBX_READ && !host_nibble_bus_oe_n);
   cov_and_c: cover property (rise && st_reg.phase == NBX_WRITE && st_reg.op == `NBX_OP_AND);
   cov_cs_c: cover property (chip_select_n && fall);
   cov_or_c: cover property (rise && st_reg.phase == NBX_WRITE && st_reg.op == `NBX_OP_OR);

   // Mask of the addressed slot; the other three must never move on a write
   logic [15:0] slot_mask;
   assign slot_mask = 16'hf000 >> {st_reg.addr, 2'b00};

   // Capture and decode
   capture_only_edge_a: assert property (
      (chip_select_n || !fall)
      |=> (st_reg.op == $past(st_reg.op) && st_reg.addr == $past(st_reg.addr)))
      else $error("opcode or address moved without a falling strobe");

   read_decode_a: assert property (
      (!chip_select_n && fall && host_nibble_bus_in[3:2] == `NBX_OP_READ)
      |=> st_reg.phase == NBX_READ)
      else $error("read code not decoded as read");

   write_entry_a: assert property (
      (!chip_select_n && fall && host_nibble_bus_in[3:2] != `NBX_OP_READ)
      |=> st_reg.phase == NBX_WRITE)
      else $error("write code did not wait for its data nibble");

   write_done_a: assert property (
      (!chip_select_n && rise && st_reg.phase == NBX_WRITE)
      |=> st_reg.phase == NBX_IDLE)
      else $error("write not closed by the data nibble");

   idle_rise_a: assert property (
      (st_reg.phase == NBX_IDLE && rise)
      |=> st_reg.phase == NBX_IDLE)
      else $error("stray rising strobe left idle");

   // Port selection
   port_a_map_a: assert property (
      (!chip_select_n && rise && st_reg.phase == NBX_WRITE
       && st_reg.op == `NBX_OP_DIRECT && st_reg.addr == 2'h0)
      |=> io_port_out.port_a == $past(host_nibble_bus_in))
      else $error("pattern 00 did not reach the first port");

   port_b_map_a: assert property (
      (!chip_select_n && rise && st_reg.phase == NBX_WRITE
       && st_reg.op == `NBX_OP_DIRECT && st_reg.addr == 2'h1)
      |=> io_port_out.port_b == $past(host_nibble_bus_in))
      else $error("pattern 01 did not reach the second port");

   port_c_map_a: assert property (
      (!chip_select_n && rise && st_reg.phase == NBX_WRITE
       && st_reg.op == `NBX_OP_DIRECT && st_reg.addr == 2'h2)
      |=> io_port_out.port_c == $past(host_nibble_bus_in))
      else $error("pattern 10 did not reach the third port");

   port_d_map_a: assert property (
      (!chip_select_n && rise && st_reg.phase == NBX_WRITE
       && st_reg.op == `NBX_OP_DIRECT && st_reg.addr == 2'h3)
      |=> io_port_out.port_d == $past(host_nibble_bus_in))
      else $error("pattern 11 did not reach the fourth port");

   port_c_read_a: assert property (
      (!chip_select_n && fall && host_nibble_bus_in == 4'h2)
      |=> io_port_oe_n == ($past(io_port_oe_n) | 4'h2))
      else $error("read of the third port released the wrong pins");

   write_sel_only_a: assert property (
      (!chip_select_n && rise && st_reg.phase == NBX_WRITE)
      |=> (st_reg.latch & ~slot_mask) == $past(st_reg.latch & ~slot_mask))
      else $error("write touched an unselected port");

   // Port latches and drivers
   latch_only_write_a: assert property (
      (chip_select_n || !rise || st_reg.phase != NBX_WRITE)
      |=> st_reg.latch == $past(st_reg.latch))
      else $error("port latch changed without a write");

   drive_only_write_a: assert property (
      (chip_select_n || !rise || st_reg.phase != NBX_WRITE)
      |=> (~io_port_oe_n & $past(io_port_oe_n)) == 4'h0)
      else $error("port started driving without a write");

   release_only_read_a: assert property (
      (chip_select_n || !fall || host_nibble_bus_in[3:2] != `NBX_OP_READ)
      |=> (io_port_oe_n & ~$past(io_port_oe_n)) == 4'h0)
      else $error("port released without a read");

   read_port_off_a: assert property (
      st_reg.phase == NBX_READ
      |-> io_port_oe_n[3 - st_reg.addr])
      else $error("port driven during its read");

   // Read timing
   read_hold_a: assert property (
      (st_reg.phase == NBX_READ && !chip_select_n && !transfer_strobe && !fall)
      |=> st_reg.phase == NBX_READ)
      else $error("read ended while strobe low");

   read_track_a: assert property (
      (st_reg.phase == NBX_READ && !chip_select_n && !fall)
      |=> host_nibble_bus_out == $past(sel_pins))
      else $error("read data not following the port pins");

   read_drive_time_a: assert property (
      (!chip_select_n && fall && host_nibble_bus_in[3:2] == `NBX_OP_READ)
      ##1 (!chip_select_n && !transfer_strobe)
      ##1 (!chip_select_n && !transfer_strobe)
      |-> !host_nibble_bus_oe_n)
      else $error("read data not on bus two cycles after fall");

   // Host bus direction and chip select
   bus_off_deselect_a: assert property (
      chip_select_n
      |-> host_nibble_bus_oe_n)
      else $error("host bus driven while deselected");

   bus_off_high_a: assert property (
      transfer_strobe
      |-> host_nibble_bus_oe_n)
      else $error("host bus driven while strobe high");

   bus_only_read_a: assert property (
      st_reg.phase != NBX_READ
      |-> host_nibble_bus_oe_n)
      else $error("host bus driven outside a read");

   ports_frozen_off_a: assert property (
      chip_select_n
      |=> (io_port_oe_n == $past(io_port_oe_n) && io_port_out == $past(io_port_out)))
      else $error("port pins changed while deselected");

   // Power-on
   poweron_exit_a: assert property (
      (st_reg.phase == NBX_POWERON && fall && !chip_select_n)
      |=> st_reg.phase != NBX_POWERON)
      else $error("first falling strobe did not leave power-on");

   poweron_hold_a: assert property (
      (st_reg.phase == NBX_POWERON && (chip_select_n || !fall))
      |=> st_reg.phase == NBX_POWERON)
      else $error("power-on left without a falling strobe");

endmodule

// File: rtl/nbx_pkg.sv
// Types for the nibble bus I/O expander
package nbx_pkg;
   typedef enum logic [1:0] {
      NBX_POWERON = 2'h0,
      NBX_IDLE    = 2'h1,
      NBX_WRITE   = 2'h3,
      NBX_READ    = 2'h2
   } nbx_phase_t;

   typedef struct packed {
      logic [3:0] port_a;
      logic [3:0] port_b;
      logic [3:0] port_c;
      logic [3:0] port_d;
   } nbx_ports_t;

   typedef struct packed {
      nbx_phase_t  phase;
      logic        strobe_q;
      logic [1:0]  op;
      logic [1:0]  addr;
      logic [15:0] latch;
      logic [3:0]  driving;
      logic [3:0]  rd_data;
      logic        rd_ready;
   } nbx_state_t;
endpackage

// File: verification/nbx_host.sv
// Host model driving strobe, select and nibble bus of the expander
`timescale 1ns/1ps
module nbx_host (
   input  wire logic       clock,
   output logic            strobe,
   output logic            cs_n,
   output logic [3:0]      bus,
   input  wire logic [4:0] rd_bus
);
   initial begin
      strobe = 1'b1;
      cs_n = 1'b0;
      bus = 4'h0;
   end
   task automatic xfer(input logic sel_n, input logic [1:0] op, input logic [1:0] port,
                       input logic [3:0] data, output logic [4:0] rd);
      @(posedge clock);
      cs_n <= sel_n;
      strobe <= 1'b0;
      bus <= {op, port};
      @(posedge clock);
      if (op == 2'h0) bus <= ~{op, port};
      repeat (3) @(posedge clock);
      @(negedge clock);
      rd = rd_bus;
      @(posedge clock);
      strobe <= 1'b1;
      bus <= data;
      repeat (2) @(posedge clock);
      @(negedge clock);
   endtask
endmodule

// File: verification/tb.sv
// Self-checking bench for the nibble bus I/O expander
`timescale 1ns/1ps
module tb;
   import nbx_pkg::*;
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic        strobe, cs_n, host_nibble_bus_oe_n;
   logic [3:0]  bus, host_nibble_bus_out, io_port_oe_n;
   nbx_ports_t  io_port_out, io_port_in;
   logic [15:0] ext, mask;
   logic [3:0]  exp [4];
   logic [4:0]  rd;
   int          miscompares = 0, check_count = 0;
   always #10 clock = ~clock;
   // Released pins show the outside world, driven ones our own value
   assign mask = {{4{io_port_oe_n[3]}}, {4{io_port_oe_n[2]}},
                  {4{io_port_oe_n[1]}}, {4{io_port_oe_n[0]}}};
   assign io_port_in = nbx_ports_t'((ext & mask) | (io_port_out & ~mask));
   nbx_host nbx_host_inst (.clock(clock), .strobe(strobe), .cs_n(cs_n), .bus(bus),
                           .rd_bus({host_nibble_bus_oe_n, host_nibble_bus_out}));
   nbx_expander nbx_expander_inst (.clock(clock), .rstn(rstn), .transfer_strobe(strobe),
      .chip_select_n(cs_n), .host_nibble_bus_in(bus), .host_nibble_bus_out(host_nibble_bus_out),
      .host_nibble_bus_oe_n(host_nibble_bus_oe_n), .io_port_in(io_port_in),
      .io_port_out(io_port_out), .io_port_oe_n(io_port_oe_n));
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      check_count++;
      if (seen !== want) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      ext <= 16'h0;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      @(negedge clock);
      check(io_port_oe_n, 4'hf);
      check(host_nibble_bus_oe_n, 1'b1);
      $display("test power_on done");
      for (int p = 0; p < 4; p++) begin
         nbx_host_inst.xfer(1'b0, 2'h1, p[1:0], 4'h3 + p[3:0], rd);
         exp[p] = 4'h3 + p[3:0];
      end
      check(io_port_out, {exp[0], exp[1], exp[2], exp[3]});
      check(io_port_oe_n, 4'h0);
      $display("test direct_write done");
      nbx_host_inst.xfer(1'b0, 2'h2, 2'h0, 4'ha, rd);
      nbx_host_inst.xfer(1'b0, 2'h3, 2'h1, 4'h6, rd);
      check(io_port_out, {4'hb, 4'h4, exp[2], exp[3]});
      $display("test or_and done");
      nbx_host_inst.xfer(1'b1, 2'h1, 2'h2, 4'hf, rd);
      check(io_port_out, {4'hb, 4'h4, exp[2], exp[3]});
      $display("test deselected done");
      ext <= 16'h0090;
      // first read after a write thrown away
      nbx_host_inst.xfer(1'b0, 2'h0, 2'h2, 4'h0, rd);
      nbx_host_inst.xfer(1'b0, 2'h0, 2'h2, 4'h0, rd);
      check(rd, 5'h09);
      check(io_port_oe_n, 4'h2);
      check(host_nibble_bus_oe_n, 1'b1);
      $display("test read done");
      end_of_test();
   end
   initial begin
      #50000;
      miscompares++;
      end_of_test();
   end
endmodule
